/* pstx_regs.vh */
// Purpose: constants for the seven-to-one pixel link transmitter
// Assumes: 40 MHz reference clock, APB register access
// Notes: included by the serializer top only
//
// Overview of operation
// - input word is 28 bits: 8 red, 8 green, 8 blue, 4 control lines
// - four serial data lanes, each with positive and negative output
// - by default the word is captured on the falling pixel clock edge
// - strobe select high captures on rising edge; low or open, falling edge
// - power-down low puts all lane and clock outputs in high impedance
// - seven bit slots per lane each pixel period, tracked from the pixel clock
// - outputs stay idle while locking; toggling begins within 10 ms
// - power-down is accepted at any moment and stops all activity
// - outputs reach high impedance within 100 ns of power-down
`ifndef PSTX_REGS_VH
`define PSTX_REGS_VH

// ==========================================================
// register map (byte addresses)
`define PSTX_ADDR_CTRL 8'h00
`define PSTX_ADDR_STATUS 8'h04
`define PSTX_ADDR_FLAGS 8'h08
`define PSTX_ADDR_PERIOD 8'h0C
`define PSTX_CTRL_RESET 2'h1
`define PSTX_CTRL_ENABLE_BIT 0
`define PSTX_CTRL_HOLD_BIT 1
`define PSTX_FLAG_OVERFLOW_BIT 0
`define PSTX_FLAG_LOST_BIT 1
`define PSTX_FLAG_TIMEOUT_BIT 2

// ==========================================================
// word layout
`define PSTX_WORD_W 28
`define PSTX_RED_POS 0
`define PSTX_GREEN_POS 8
`define PSTX_BLUE_POS 16
`define PSTX_LINE_POS 24
`define PSTX_FRAME_POS 25
`define PSTX_VALID_POS 26
`define PSTX_SPARE_POS 27
`define PSTX_LANES 4
`define PSTX_SLOTS 7
`define PSTX_CLK_HIGH_SLOTS 4
`define PSTX_FIFO_DEPTH 8
`define PSTX_FIFO_AW 3

// ==========================================================
// timing
`define PSTX_REF_MHZ 40
`define PSTX_SHUTDOWN_DELAY_NS 100
`define PSTX_SHUTDOWN_DELAY_CYC ((`PSTX_SHUTDOWN_DELAY_NS * `PSTX_REF_MHZ) / 1000)
`define PSTX_TPLLS_MS 10
`define PSTX_TPLLS_CYC (`PSTX_TPLLS_MS * `PSTX_REF_MHZ * 1000)
`define PSTX_LOCK_EDGES 3'h4
`define PSTX_PERIOD_MAX 8'hF0

`endif

/* pstx_mem.v */
// Purpose: word store for the capture fifo
// Assumes: one write and one read port, same clock
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module pstx_mem #(
  parameter W = 28,
  parameter D = 8,
  parameter AW = 3
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [W-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [W-1:0] o_rdata
);
  reg [W-1:0] mem [0:D-1];

  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= {W{1'b0}};
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // pstx_mem

/* pstx_fifo.v */
// Purpose: capture fifo between pixel capture and serializer
// Assumes: depth is a power of two
// Notes: head is valid one cycle after any push or pop settles
`timescale 1ns/1ps
module pstx_fifo #(
  parameter W = 28,
  parameter D = 8,
  parameter AW = 3
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data,
  output reg [AW:0] o_count
);
  localparam [AW:0] FULL = D[AW:0];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg settled;
  wire push;
  wire pop;

  assign o_in_ready = (o_count != FULL) && !i_flush;
  // registered read lags a pointer move by one cycle
  assign o_out_valid = (o_count != {(AW+1){1'b0}}) && settled && !i_flush;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      o_count <= {(AW+1){1'b0}};
      settled <= 1'b0;
    end else if (i_flush) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      o_count <= {(AW+1){1'b0}};
      settled <= 1'b0;
    end else begin
      settled <= !(push || pop);
      if (push) begin
        wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rptr <= rptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        o_count <= o_count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        o_count <= o_count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  pstx_mem #(.W(W), .D(D), .AW(AW)) u_mem (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_we(push),
    .i_waddr(wptr),
    .i_wdata(i_in_data),
    .i_raddr(rptr),
    .o_rdata(o_out_data)
  );
endmodule // pstx_fifo

/* pstx_serializer.v */
// Purpose: seven-to-one pixel link transmitter with APB status and control
// Assumes: pixel clock period is at least seven reference cycles
// Notes: one bit slot per reference cycle; spare cycles of a period idle low
`timescale 1ns/1ps
`include "pstx_regs.vh"
module pstx_serializer #(
  parameter P_LOCK_MAX_CYC = `PSTX_TPLLS_CYC
) (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_pixel_clock_in,
  input wire i_strobe_edge_select,
  input wire i_power_down_n,
  input wire [7:0] i_red,
  input wire [7:0] i_green,
  input wire [7:0] i_blue,
  input wire i_line_sync,
  input wire i_frame_sync,
  input wire i_pixel_data_valid,
  input wire i_ctrl_spare,
  output wire [3:0] o_serial_lane_out_p,
  output wire [3:0] o_serial_lane_out_n,
  output reg o_serial_lane_oe,
  output reg o_forwarded_clock_out_p,
  output reg o_forwarded_clock_out_n,
  output reg o_forwarded_clock_oe
);
  localparam [1:0] ST_OFF = 2'd0;
  localparam [1:0] ST_ACQ = 2'd1;
  localparam [1:0] ST_LOCK = 2'd2;
  localparam [31:0] LOCK_LAST = P_LOCK_MAX_CYC - 1;
  localparam integer MIN_GAP_I = `PSTX_SLOTS - 1;
  localparam integer CLK_HIGH_I = `PSTX_CLK_HIGH_SLOTS;
  localparam [7:0] MIN_GAP = MIN_GAP_I[7:0];
  localparam [2:0] LAST_SLOT = MIN_GAP_I[2:0];
  localparam [2:0] CLK_HIGH = CLK_HIGH_I[2:0];

  // ==========================================================
  // input synchronisers
  reg [2:0] clk_sync;
  reg [1:0] sel_sync;
  reg [1:0] pd_sync;
  reg [`PSTX_WORD_W-1:0] data_s1;
  reg [`PSTX_WORD_W-1:0] data_s2;
  wire [`PSTX_WORD_W-1:0] in_word;

  assign in_word = {i_ctrl_spare, i_pixel_data_valid, i_frame_sync, i_line_sync,
                    i_blue, i_green, i_red};

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_sync <= 3'h0;
      sel_sync <= 2'h0;
      pd_sync <= 2'h0;
      data_s1 <= {`PSTX_WORD_W{1'b0}};
      data_s2 <= {`PSTX_WORD_W{1'b0}};
    end else begin
      clk_sync <= {clk_sync[1:0], i_pixel_clock_in};
      sel_sync <= {sel_sync[0], i_strobe_edge_select};
      pd_sync <= {pd_sync[0], i_power_down_n};
      data_s1 <= in_word;
      data_s2 <= data_s1;
    end
  end

  // ==========================================================
  // registers
  reg [1:0] ctrl;
  reg [2:0] flags;
  wire ctrl_enable;
  wire drain_hold;
  wire powered;
  wire rise;
  wire fall;
  wire strobe;

  assign ctrl_enable = ctrl[`PSTX_CTRL_ENABLE_BIT];
  assign drain_hold = ctrl[`PSTX_CTRL_HOLD_BIT];
  // pin path is sync stage pair plus oe flop: three cycles, inside the budget
  assign powered = pd_sync[1] && ctrl_enable;
  assign rise = clk_sync[1] && !clk_sync[2];
  assign fall = !clk_sync[1] && clk_sync[2];
  assign strobe = sel_sync[1] ? rise : fall;

  // ==========================================================
  // lock tracking of the pixel clock
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] period_cnt;
  reg [7:0] last_period;
  reg [2:0] good_edges;
  reg [31:0] wait_cnt;
  reg lost_evt;
  reg timeout_evt;
  wire gap_ok;
  wire gap_over;
  wire locked;

  assign gap_ok = (period_cnt >= MIN_GAP) && (period_cnt != `PSTX_PERIOD_MAX);
  assign gap_over = (period_cnt == `PSTX_PERIOD_MAX);
  assign locked = (state == ST_LOCK);

  always @* begin
    next_state = state;
    lost_evt = 1'b0;
    timeout_evt = 1'b0;
    case (state)
      ST_OFF: begin
        next_state = ST_ACQ;
      end
      ST_ACQ: begin
        if (wait_cnt == LOCK_LAST) begin
          timeout_evt = 1'b1;
        end
        if (strobe && gap_ok && (good_edges == `PSTX_LOCK_EDGES - 3'h1)) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if ((strobe && !gap_ok) || gap_over) begin
          lost_evt = 1'b1;
          next_state = ST_ACQ;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!powered) begin
      next_state = ST_OFF;
    end
  end

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_OFF;
      period_cnt <= 8'h00;
      last_period <= 8'h00;
      good_edges <= 3'h0;
      wait_cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (!powered || strobe) begin
        period_cnt <= 8'h00;
      end else if (!gap_over) begin
        period_cnt <= period_cnt + 8'h01;
      end
      if (strobe) begin
        last_period <= period_cnt + 8'h01;
      end
      if (state != ST_ACQ) begin
        good_edges <= 3'h0;
      end else if (strobe) begin
        good_edges <= gap_ok ? good_edges + 3'h1 : 3'h0;
      end else if (gap_over) begin
        good_edges <= 3'h0;
      end
      if (state != ST_ACQ) begin
        wait_cnt <= 32'h0000_0000;
      end else if (wait_cnt != LOCK_LAST) begin
        wait_cnt <= wait_cnt + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // capture fifo
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`PSTX_WORD_W-1:0] fifo_out_data;
  wire [`PSTX_FIFO_AW:0] fifo_count;
  wire push_req;
  wire load;
  wire overflow_evt;

  assign push_req = strobe && locked;
  // head is taken at each strobe unless drain hold is set, so a word leaves one period after capture
  assign load = strobe && locked && !drain_hold && fifo_out_valid;
  assign overflow_evt = push_req && !fifo_in_ready;

  pstx_fifo #(.W(`PSTX_WORD_W), .D(`PSTX_FIFO_DEPTH), .AW(`PSTX_FIFO_AW)) u_fifo (
    .i_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_flush(!locked),
    .i_in_valid(push_req),
    .o_in_ready(fifo_in_ready),
    .i_in_data(data_s2),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(load),
    .o_out_data(fifo_out_data),
    .o_count(fifo_count)
  );

  // ==========================================================
  // serializer
  reg [2:0] slot;
  reg active;
  reg [3:0] lane_p;
  reg [3:0] lane_n;

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot <= 3'h0;
      active <= 1'b0;
      o_forwarded_clock_out_p <= 1'b0;
      o_forwarded_clock_out_n <= 1'b1;
      o_serial_lane_oe <= 1'b0;
      o_forwarded_clock_oe <= 1'b0;
    end else begin
      o_serial_lane_oe <= powered;
      o_forwarded_clock_oe <= powered;
      if (!locked) begin
        active <= 1'b0;
        slot <= 3'h0;
        o_forwarded_clock_out_p <= 1'b0;
        o_forwarded_clock_out_n <= 1'b1;
      end else if (strobe) begin
        active <= 1'b1;
        slot <= 3'h1;
        o_forwarded_clock_out_p <= 1'b1;
        o_forwarded_clock_out_n <= 1'b0;
      end else if (active) begin
        active <= (slot != LAST_SLOT);
        slot <= slot + 3'h1;
        o_forwarded_clock_out_p <= (slot < CLK_HIGH) && (slot != LAST_SLOT);
        o_forwarded_clock_out_n <= !((slot < CLK_HIGH) && (slot != LAST_SLOT));
      end else begin
        o_forwarded_clock_out_p <= 1'b0;
        o_forwarded_clock_out_n <= 1'b1;
      end
    end
  end

  genvar ln;
  generate
    for (ln = 0; ln < `PSTX_LANES; ln = ln + 1) begin : g_lane
      reg [`PSTX_SLOTS-1:0] sr;
      always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sr <= {`PSTX_SLOTS{1'b0}};
          lane_p[ln] <= 1'b0;
          lane_n[ln] <= 1'b1;
        end else if (!locked) begin
          sr <= {`PSTX_SLOTS{1'b0}};
          lane_p[ln] <= 1'b0;
          lane_n[ln] <= 1'b1;
        end else if (strobe) begin
          // lane ln, slot s carries word bit ln*7+s; empty fifo sends zeros
          sr <= load ? fifo_out_data[ln*`PSTX_SLOTS +: `PSTX_SLOTS] : {`PSTX_SLOTS{1'b0}};
          lane_p[ln] <= load && fifo_out_data[ln*`PSTX_SLOTS];
          lane_n[ln] <= !(load && fifo_out_data[ln*`PSTX_SLOTS]);
        end else if (active && (slot <= LAST_SLOT)) begin
          lane_p[ln] <= sr[slot];
          lane_n[ln] <= !sr[slot];
        end else begin
          lane_p[ln] <= 1'b0;
          lane_n[ln] <= 1'b1;
        end
      end
    end
  endgenerate

  assign o_serial_lane_out_p = lane_p;
  assign o_serial_lane_out_n = lane_n;

  // ==========================================================
  // apb slave
  wire wr;
  wire setup;
  wire hit;
  reg [31:0] rd_mux;

  assign wr = i_psel && i_penable && i_pwrite;
  assign setup = i_psel && !i_penable;
  assign hit = (i_paddr == `PSTX_ADDR_CTRL) || (i_paddr == `PSTX_ADDR_STATUS) ||
               (i_paddr == `PSTX_ADDR_FLAGS) || (i_paddr == `PSTX_ADDR_PERIOD);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `PSTX_ADDR_CTRL: rd_mux = {30'h0000_0000, ctrl};
      `PSTX_ADDR_STATUS: rd_mux = {24'h00_0000, fifo_count, 1'b0, sel_sync[1], !pd_sync[1], locked};
      `PSTX_ADDR_FLAGS: rd_mux = {29'h0000_0000, flags};
      `PSTX_ADDR_PERIOD: rd_mux = {24'h00_0000, last_period};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= `PSTX_CTRL_RESET;
      flags <= 3'h0;
      o_prdata <= 32'h0000_0000;
    end else begin
      if (setup) begin
        o_prdata <= rd_mux;
      end
      if (wr && (i_paddr == `PSTX_ADDR_CTRL)) begin
        ctrl <= i_pwdata[1:0];
      end
      // write one to clear; a new event in the same cycle wins
      flags <= (flags & ~((wr && (i_paddr == `PSTX_ADDR_FLAGS)) ? i_pwdata[2:0] : 3'h0)) |
               {timeout_evt, lost_evt, overflow_evt};
    end
  end
endmodule // pstx_serializer

/* pstx_serializer_chk.sv */
// Purpose: port checks for the pixel link transmitter
// Assumes: one 40 MHz domain, async active-low reset
// Notes: pin power-down silences the shape checks, p/n mean nothing then
`timescale 1ns/1ps
module pstx_serializer_chk (
  input logic i_ref_clk,
  input logic i_arst_n,
  input logic i_psel,
  input logic i_penable,
  input logic [7:0] i_paddr,
  input logic o_pready,
  input logic o_pslverr,
  input logic i_power_down_n,
  input logic [3:0] o_serial_lane_out_p,
  input logic [3:0] o_serial_lane_out_n,
  input logic o_serial_lane_oe,
  input logic o_forwarded_clock_out_p,
  input logic o_forwarded_clock_out_n,
  input logic o_forwarded_clock_oe
);
  // ==========================================
  // link and bus properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_hi; o_forwarded_clock_out_p [*4]; endsequence
  sequence s_lo; !o_forwarded_clock_out_p [*3]; endsequence
  property p_pd_off; $fell(i_power_down_n) |-> ##[1:4] !o_serial_lane_oe; endproperty
  a_pd_off: assert property (p_pd_off) else $error("lanes driven too long");
  property p_pd_hold; !i_power_down_n [*4] |-> !o_serial_lane_oe && !o_forwarded_clock_oe; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("driven in power-down");
  property p_oe_pair; o_serial_lane_oe == o_forwarded_clock_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  property p_lane_diff; o_serial_lane_oe |-> o_serial_lane_out_n == ~o_serial_lane_out_p; endproperty
  a_lane_diff: assert property (p_lane_diff) else $error("lane pair not complementary");
  property p_clk_diff; o_forwarded_clock_oe |-> o_forwarded_clock_out_n == !o_forwarded_clock_out_p; endproperty
  a_clk_diff: assert property (p_clk_diff) else $error("clock pair not complementary");
  property p_clk_shape;
    disable iff (!i_arst_n || !i_power_down_n) $rose(o_forwarded_clock_out_p) && o_forwarded_clock_oe |-> s_hi ##1 s_lo;
  endproperty
  a_clk_shape: assert property (p_clk_shape) else $error("clock pulse shape");
  property p_idle;
    disable iff (!i_arst_n || !i_power_down_n)
      (!o_forwarded_clock_out_p && o_serial_lane_oe) [*4] |-> o_serial_lane_out_p == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("lanes busy outside slots");
  property p_apb; i_psel && i_penable |-> o_pready && o_pslverr == (i_paddr > 8'h0c || i_paddr[1:0] != 2'h0); endproperty
  a_apb: assert property (p_apb) else $error("bus answer wrong");
endmodule // pstx_serializer_chk

bind pstx_serializer pstx_serializer_chk pstx_serializer_chk_i (.i_ref_clk, .i_arst_n, .i_psel, .i_penable,
  .i_paddr, .o_pready, .o_pslverr, .i_power_down_n, .o_serial_lane_out_p, .o_serial_lane_out_n,
  .o_serial_lane_oe, .o_forwarded_clock_out_p, .o_forwarded_clock_out_n, .o_forwarded_clock_oe);

/* pstx_ctl_model.sv */
// Purpose: graphics controller model, pixel clock and words
// Assumes: 200 ns pixel period; clock parks low when stopped
// Notes: words change on the other edge, far from capture
`timescale 1ns/1ps
module pstx_ctl_model (
  input wire logic i_run,
  input wire logic i_edge,
  output logic o_pclk,
  output logic [27:0] o_word,
  output logic [27:0] o_prev
);
  logic [27:0] cur;
  // ==========================================
  // pixel clock and data
  initial begin
    o_pclk = 1'h0;
    o_word = 28'h0;
    o_prev = 28'h0;
    cur = 28'h0;
    #7.3;
    forever begin
      #100;
      if (i_run || o_pclk) begin
        o_pclk = ~o_pclk;
        if (o_pclk == i_edge) begin
          o_prev = cur;
          cur = o_word;
        end else begin
          o_word = 28'($urandom);
        end
      end
    end
  end
endmodule // pstx_ctl_model

/* pstx_serializer_tb.sv */
// Purpose: self-checking bench for the pixel link transmitter
// Assumes: pixel period of eight reference cycles
// Notes: lock timeout shortened to 200 cycles
`timescale 1ns/1ps
module pstx_serializer_tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pd_n = 0, esel = 0, run = 0, cmp_on = 0, fd = 0;
  logic pready, perr, pclk, fp, fn, foe, loe;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [27:0] word, prev, got, exp_w;
  logic [3:0] lp, ln;
  int bad_count = 0, checks_done = 0, cyc = 0, slot = 7, k;
  always #12.5 clk = ~clk;
  pstx_ctl_model pstx_ctl_model_i (.i_run(run), .i_edge(esel), .o_pclk(pclk), .o_word(word), .o_prev(prev));
  pstx_serializer #(.P_LOCK_MAX_CYC(200)) pstx_serializer_i (.i_ref_clk(clk), .i_arst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .i_pixel_clock_in(pclk), .i_strobe_edge_select(esel), .i_power_down_n(pd_n),
    .i_red(word[7:0]), .i_green(word[15:8]), .i_blue(word[23:16]), .i_line_sync(word[24]),
    .i_frame_sync(word[25]), .i_pixel_data_valid(word[26]), .i_ctrl_spare(word[27]), .o_serial_lane_out_p(lp),
    .o_serial_lane_out_n(ln), .o_serial_lane_oe(loe), .o_forwarded_clock_out_p(fp),
    .o_forwarded_clock_out_n(fn), .o_forwarded_clock_oe(foe));
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    r = prdata;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  // ==========================================
  // frame monitor; expected word is the one held at the previous strobe
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      stop_test();
    end
    if (fp === 1'h1 && fd === 1'h0) begin
      slot = 0;
      exp_w = prev;
    end
    if (slot < 7) begin
      for (int l = 0; l < 4; l++) got[l * 7 + slot] = lp[l];
      if (slot == 6 && cmp_on) chk({4'h0, got}, {4'h0, exp_w});
      slot++;
    end
    fd = fp;
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'h3356));
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    apb(1'h0, 8'h10, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(r, 32'h1);
    $display("test registers done");
    for (int e = 0; e < 2; e++) begin
      repeat ($urandom_range(7)) @(posedge clk);
      pd_n <= 1'h0;
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (loe !== 1'h0 && k < 10);
      chk(k <= 100 / 25, 1'h1);
      run = 1'h0;
      @(posedge clk);
      esel <= e[0];
      repeat (20) @(posedge clk);
      apb(1'h0, 8'h04, 32'h0);
      chk({r[7:4], r[0]}, 32'h0);
      run = 1'h1;
      repeat (24) @(posedge clk);
      pd_n <= 1'h1;
      k = 0;
      r = 0;
      while (r[0] !== 1'h1 && k < 40) begin
        apb(1'h0, 8'h04, 32'h0);
        k++;
      end
      chk(r[2:0], {e[0], 2'h1});
      apb(1'h0, 8'h0c, 32'h0);
      chk(r, 32'h8);
      repeat (16) @(posedge clk);
      cmp_on <= 1'h1;
      repeat (160) @(posedge clk);
      cmp_on <= 1'h0;
      $display("test strobe edge %0d done", e);
    end
    apb(1'h1, 8'h00, 32'h3);
    repeat (120) @(posedge clk);
    apb(1'h0, 8'h04, 32'h0);
    chk(r[7:4], 32'h8);
    apb(1'h0, 8'h08, 32'h0);
    chk(r[0], 32'h1);
    $display("test hold done");
    stop_test();
  end
endmodule // pstx_serializer_tb
